// ===== logic/aux_entry.sv
// Manchester auxiliary entry detector and EEPROM write completion signal.
// Assumes the sensor line pin is asynchronous and the tick and PWM period
// figures come from the output protocol logic on the same clock.
`timescale 1ns/1ps
`include "aux_entry_consts.svh"
module aux_entry
   import aux_entry_pkg::*;
#(
   parameter int unsigned FIRST_EDGE_CYC = `FIRST_EDGE_CYCLES,
   parameter int unsigned WRITE_CYC      = `WRITE_CYCLES
)
(
   // Clock and reset.
   input  wire logic               clk_in,
   input  wire logic               rst_in,
   // Open-drain sensor output line.
   input  wire logic               sensor_output_line_in,
   output logic                    sensor_output_line_out,
   output logic                    sensor_output_line_oe_out,
   // Normal protocol output and its context.
   input  wire logic               normal_drive_low_in,
   input  wire out_mode_type       mode_in,
   input  wire logic               tick_in,
   input  wire logic               sent_frame_window_in,
   input  wire logic [`CNT_W-1:0]  pwm_period_cyc_in,
   // Serial engine handshake.
   input  wire logic               eeprom_write_in,
   input  wire logic               comm_exit_in,
   // Status.
   output logic                    comm_active_out,
   output logic                    entry_abort_out
);

   logic                line_meta;      // First synchroniser stage.
   logic                line_sync;      // Second synchroniser stage.
   logic                line_prev;      // Previous synchronised level.
   entry_state_type     state;          // Entry sequence state.
   logic [`CNT_W-1:0]   low_cyc;        // Cycles the line has been low.
   logic [`CNT_W-1:0]   low_ticks;      // Ticks the line has been low.
   logic [`CNT_W-1:0]   phase_cyc;      // Cycles spent in the current phase.
   logic                low_in_window;  // Low pulse began inside a SENT frame.
   logic                hold_ok;        // Low pulse qualifies as an entry request.
   logic                polled_mode;    // One of the polled SENT modes.
   logic                rise;           // Synchronised rising edge.
   logic                fall;           // Synchronised falling edge.

   // Two flip-flop synchroniser on the shared line.
   always_ff @(posedge clk_in)
   begin
      if (rst_in)
      begin
         line_meta <= 1'b1;
         line_sync <= 1'b1;
         line_prev <= 1'b1;
      end
      else
      begin
         line_meta <= sensor_output_line_in;
         line_sync <= line_meta;
         line_prev <= line_sync;
      end
   end

   assign rise = line_sync & ~line_prev;
   assign fall = ~line_sync & line_prev;
   assign polled_mode = (mode_in == MODE_SYNC_SHORT) || (mode_in == MODE_SYNC_LONG)
                        || (mode_in == MODE_ID_POLLED);

   // Low pulse counters in cycles and in ticks; they restart on each fall.
   always_ff @(posedge clk_in)
   begin
      if (rst_in)
      begin
         low_cyc   <= '0;
         low_ticks <= '0;
      end
      else if (fall)
      begin
         // The cycle that shows the fall is already the first low cycle.
         low_cyc   <= {{(`CNT_W-1){1'b0}}, 1'b1};  // see [RL20]
         low_ticks <= {{(`CNT_W-1){1'b0}}, tick_in};
      end
      else if (!line_sync)
      begin
         if (low_cyc != '1)
            low_cyc <= low_cyc + 1'b1;  // see [RL20]
         if (tick_in && low_ticks != '1)
            low_ticks <= low_ticks + 1'b1;
      end
   end

   // Remembers whether the low pulse started inside a SENT frame.
   always_ff @(posedge clk_in)
   begin
      if (rst_in)
         low_in_window <= 1'b0;
      else if (fall)
         low_in_window <= sent_frame_window_in;  // see [RL7]
   end

   // Decides at the rising edge whether the low pulse was an entry request.
   always_comb
   begin
      case (mode_in)
         // The period input already reflects any diagnostic frequency.
         MODE_PWM:
            hold_ok = (low_cyc >= `PWM_HOLD_PERIODS * pwm_period_cyc_in);  // see [RL2] [RL3] [RL1]
         MODE_SENT, MODE_HOST_TRIG:
            hold_ok = low_in_window && (low_ticks >= `SENT_HOLD_TICKS);  // see [RL8] [RL7]
         MODE_SYNC_SHORT:
            hold_ok = (low_ticks >= `SHORT_AUX_MIN) && (low_ticks <= `SHORT_AUX_MAX);  // see [RL11]
         MODE_SYNC_LONG:
            hold_ok = (low_ticks >= `LONG_AUX_MIN) && (low_ticks <= `LONG_AUX_MAX);  // see [RL11]
         MODE_ID_POLLED:
            hold_ok = (low_ticks >= `ID_AUX_MIN) && (low_ticks <= `ID_AUX_MAX);  // see [RL11]
         default:
            hold_ok = 1'b0;
      endcase
   end

   // Phase counter. It rests at zero where no phase is timed, so that a store
   // starts from zero, and restarts on line edges during release and host low.
   always_ff @(posedge clk_in)
   begin
      if (rst_in)
         phase_cyc <= '0;
      else if (state == ST_IDLE || state == ST_COMM || state == ST_DONE)
         phase_cyc <= '0;
      else if ((state == ST_RELEASE || state == ST_LOW) && (rise || fall))
         phase_cyc <= '0;
      else if (phase_cyc != '1)
         phase_cyc <= phase_cyc + 1'b1;
   end

   // Entry sequence: hold, release, host low, first access code edge.
   always_ff @(posedge clk_in)
   begin
      if (rst_in)
      begin
         state           <= ST_IDLE;
         entry_abort_out <= 1'b0;
      end
      else
      begin
         entry_abort_out <= 1'b0;
         case (state)
            // Watches foreign low pulses while the device is released.
            ST_IDLE:
               if (rise && hold_ok && !normal_drive_low_in)
                  state <= ST_RELEASE;  // see [RL4] [RL12]
            ST_RELEASE:
               // A release shorter than the gate time is not a registered edge.
               if (fall)
                  state <= (phase_cyc >= `GATE_CYCLES - 1) ? ST_LOW : ST_IDLE;  // see [RL4]
               else if (phase_cyc >= FIRST_EDGE_CYC)
               begin
                  state           <= ST_IDLE;  // see [RL6] [RL10] [RL14]
                  entry_abort_out <= 1'b1;
               end
            ST_LOW:
               // Host drives low; the first rise opens the access code.
               // That rise is the mid-cell edge of a zero sync bit.
               if (rise)
                  state <= ST_COMM;  // see [RL5] [RL9] [RL13] [RL18]
               else if (phase_cyc >= FIRST_EDGE_CYC)
               begin
                  state           <= ST_IDLE;  // see [RL6] [RL10] [RL14]
                  entry_abort_out <= 1'b1;
               end
            // Bit rate and coding are handled by the serial engine, which
            // answers at the rate of the command it received.
            ST_COMM:  // see [RL17] [RL19]
               if (eeprom_write_in)
                  state <= ST_STORE;  // see [RL15]
               else if (comm_exit_in)
                  state <= ST_IDLE;
            ST_STORE:
               if (phase_cyc >= WRITE_CYC - 1)
                  state <= ST_DONE;  // see [RL15]
            ST_DONE:
               state <= ST_COMM;  // see [RL16]
            default:
               state <= ST_IDLE;
         endcase
      end
   end

   // Line drive: normal protocol only when idle, low pulse when store ends.
   always_ff @(posedge clk_in)
   begin
      if (rst_in)
         sensor_output_line_oe_out <= 1'b0;
      else if (state == ST_IDLE && !(rise && hold_ok))
         sensor_output_line_oe_out <= normal_drive_low_in;
      else
         sensor_output_line_oe_out <= (state == ST_DONE);  // see [RL16] [RL12]
   end

   assign sensor_output_line_out = 1'b0;
   assign comm_active_out = (state == ST_COMM) || (state == ST_STORE) || (state == ST_DONE);

   property p_abort_timeout;
      @(posedge clk_in) disable iff (rst_in)
      (state == ST_LOW && phase_cyc >= FIRST_EDGE_CYC && !rise) |=> entry_abort_out;
   endproperty
   a_abort_timeout: assert property (p_abort_timeout) else $error("No abort on timeout."); // see [RL6]

   property p_abort_idle;
      @(posedge clk_in) disable iff (rst_in)
      entry_abort_out |-> state == ST_IDLE;
   endproperty
   a_abort_idle: assert property (p_abort_idle) else $error("Abort left entry open."); // see [RL10]

   property p_polled_window;
      @(posedge clk_in) disable iff (rst_in)
      (state == ST_IDLE && rise && polled_mode && !normal_drive_low_in
       && (low_ticks < `SHORT_AUX_MIN)) |=> state == ST_IDLE;
   endproperty
   a_polled_window: assert property (p_polled_window) else $error("Short pulse accepted."); // see [RL11]

   property p_pwm_short;
      @(posedge clk_in) disable iff (rst_in)
      (state == ST_IDLE && rise && mode_in == MODE_PWM
       && low_cyc < `PWM_HOLD_PERIODS * pwm_period_cyc_in)
      |=> state == ST_IDLE;
   endproperty
   a_pwm_short: assert property (p_pwm_short) else $error("Short PWM hold accepted."); // see [RL2]

   property p_sent_short;
      @(posedge clk_in) disable iff (rst_in)
      (state == ST_IDLE && rise && (mode_in == MODE_SENT || mode_in == MODE_HOST_TRIG)
       && low_ticks < `SENT_HOLD_TICKS) |=> state == ST_IDLE;
   endproperty
   a_sent_short: assert property (p_sent_short) else $error("Short SENT hold accepted."); // see [RL8]

   property p_release_undriven;
      @(posedge clk_in) disable iff (rst_in)
      (state == ST_RELEASE) |=> !sensor_output_line_oe_out;
   endproperty
   a_release_undriven: assert property (p_release_undriven) else $error("Line driven in release."); // see [RL12]

   property p_store_done;
      @(posedge clk_in) disable iff (rst_in)
      (state == ST_DONE) |=> sensor_output_line_oe_out ##1 !sensor_output_line_oe_out;
   endproperty
   a_store_done: assert property (p_store_done) else $error("No completion pulse."); // see [RL16]

   property p_store_hold;
      @(posedge clk_in) disable iff (rst_in)
      (state == ST_STORE && phase_cyc < WRITE_CYC - 1) |=> state == ST_STORE;
   endproperty
   a_store_hold: assert property (p_store_hold) else $error("Store ended early."); // see [RL15]

endmodule

// ===== logic/aux_entry_consts.svh
// Constants for the Manchester auxiliary entry and write completion block.
// Assumes a 100 MHz clock and an open-drain output line with an external pull-up.
//
// Operation
// [RL1] PWM: aux pulse accepted at any cycle point
// [RL2] PWM: low held two PWM periods minimum
// [RL3] Diagnostic PWM frequency sets the hold period
// [RL4] Release then rising edge, 0.7 us detect
// [RL5] PWM: host drives gate plus half bit
// [RL6] PWM: no first edge, resume PWM output
// [RL7] SENT: aux only from sync to last nibble
// [RL8] SENT: aux low at least 30 ticks
// [RL9] SENT: host drives gate then access code
// [RL10] SENT: no first edge, resume SENT output
// [RL11] Polled modes: function pulse width windows
// [RL12] Polled modes: line undriven after pulse
// [RL13] Polled modes: host holds low gate time
// [RL14] Polled modes: no first edge, resume output
// [RL15] EEPROM store takes about 20 ms
// [RL16] Falling edge on line marks write complete
// [RL17] Manchester rate between 4 and 100 kbps
// [RL18] One falls mid-cell, zero rises mid-cell
// [RL19] Acknowledge uses the command bit rate
// [RL20] Pulse widths measured with internal counters
`ifndef AUX_ENTRY_CONSTS_SVH
`define AUX_ENTRY_CONSTS_SVH

// Clock period in picoseconds.
`define CLK_PERIOD_PS     10000
// Edge detection time in picoseconds.
`define GATE_TIME_PS      700000
// Least cycles for edge detection, rounded up.
`define GATE_CYCLES       ((`GATE_TIME_PS + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
// First edge timeout, longest figure in microseconds.
`define FIRST_EDGE_US     300
// Cycles in the first edge timeout, rounded down.
`define FIRST_EDGE_CYCLES (`FIRST_EDGE_US * 1000000 / `CLK_PERIOD_PS)
// Program write delay in milliseconds.
`define WRITE_DELAY_MS    20
// Cycles in the write delay; the division goes first so that 32-bit math holds.
`define WRITE_CYCLES      (`WRITE_DELAY_MS * (1000000000 / `CLK_PERIOD_PS))
// Hold thresholds in ticks.
`define SENT_HOLD_TICKS   30
`define SHORT_AUX_MIN     50
`define SHORT_AUX_MAX     83
`define LONG_AUX_MIN      196
`define LONG_AUX_MAX      297
`define ID_AUX_MIN        50
`define ID_AUX_MAX        80
// Number of PWM periods in the PWM hold time.
`define PWM_HOLD_PERIODS  2
// Width of the pulse measuring counters.
`define CNT_W             32

`endif

// ===== logic/aux_entry_pkg.sv
// Types for the Manchester auxiliary entry block.
// Assumes the constants header is included by the design file.
package aux_entry_pkg;

   // Output protocol selected by the surrounding sensor logic.
   typedef enum logic [2:0]
   {
      MODE_PWM         = 3'h0,
      MODE_SENT        = 3'h1,
      MODE_HOST_TRIG   = 3'h2,
      MODE_SYNC_SHORT  = 3'h3,
      MODE_SYNC_LONG   = 3'h4,
      MODE_ID_POLLED   = 3'h5
   } out_mode_type;

   // Entry sequence states, Gray coded in declaration order; the path skips ST_HOLD.
   typedef enum logic [2:0]
   {
      ST_IDLE    = 3'h0,
      ST_HOLD    = 3'h1,
      ST_RELEASE = 3'h3,
      ST_LOW     = 3'h2,
      ST_COMM    = 3'h6,
      ST_STORE   = 3'h7,
      ST_DONE    = 3'h5
   } entry_state_type;

endpackage

// ===== tb/aux_host_model.sv
// Programming controller model that shares the open-drain sensor line.
// Assumes the bench pulls the line up and calls the tasks at a falling edge.
`timescale 1ns/1ps
module aux_host_model
(
   // Clock used to pace the line changes.
   input  wire logic clk_in,
   // High while the controller pulls the line low.
   output logic      drive_low_out
);
   // The controller starts with the line released.
   initial drive_low_out = 1'b0;

   // Sends an entry request and, if asked, the first rising access edge.
   task automatic entry(input int hold, input int gap, input int gate, input bit rise);
      drive_low_out = 1'b1;
      repeat (hold) @(negedge clk_in);
      drive_low_out = 1'b0;
      repeat (gap) @(negedge clk_in);
      if (gate > 0)
      begin
         drive_low_out = 1'b1;
         repeat (gate) @(negedge clk_in);
      end
      if (rise)
         drive_low_out = 1'b0;
   endtask

   // Lets the line go back to the pull-up.
   task automatic idle();
      drive_low_out = 1'b0;
   endtask
endmodule

// ===== tb/testbench.sv
// Self-checking bench for the auxiliary entry block.
// Assumes the design files and the controller model are compiled first.
`timescale 1ns/1ps
`include "aux_entry_consts.svh"
module testbench
   import aux_entry_pkg::*;
;
   localparam int FE = 200; // Shortened first edge timeout, above the 1.4 us floor.
   localparam int GP = 80;  // Release gap, longer than the 0.7 us edge detection.
   localparam int WR = 20; // Shortened store time.
   // One table row: mode, PWM period, frame window, hold cycles, accepted.
   typedef struct packed
   {
      out_mode_type m;
      logic [7:0]   p;
      logic         w;
      logic [11:0]  h;
      logic         a;
   } row_type;
   logic              clk_in;
   logic              rst_in;
   logic              normal_drive_low_in;
   logic              tick_in;
   logic              sent_frame_window_in;
   logic              eeprom_write_in;
   logic              comm_exit_in;
   out_mode_type      mode_in;
   logic [`CNT_W-1:0] pwm_period_cyc_in;
   logic              oe;
   logic              dout;
   logic              comm_active_out;
   logic              entry_abort_out;
   logic              host_low;
   logic [1:0]        tick_div = 2'h0;
   int                mismatches = 0;
   int                n_tests = 0;
   int                n;
   // The line falls when either party pulls it, else the pull-up wins.
   wire               line_w = ((oe && !dout) || host_low) ? 1'b0 : 1'b1;
   row_type rows [17] = '{
      '{MODE_PWM, 8'h0a, 1'b0, 12'h012, 1'b0}, '{MODE_PWM, 8'h0a, 1'b0, 12'h017, 1'b1},
      '{MODE_PWM, 8'h0a, 1'b0, 12'h013, 1'b0}, '{MODE_PWM, 8'h0a, 1'b0, 12'h014, 1'b1},
      '{MODE_PWM, 8'h14, 1'b0, 12'h017, 1'b0}, '{MODE_PWM, 8'h14, 1'b0, 12'h02b, 1'b1},
      '{MODE_SENT, 8'h0a, 1'b1, 12'h070, 1'b0}, '{MODE_SENT, 8'h0a, 1'b1, 12'h084, 1'b1},
      '{MODE_SENT, 8'h0a, 1'b0, 12'h084, 1'b0}, '{MODE_HOST_TRIG, 8'h0a, 1'b1, 12'h084, 1'b1},
      '{MODE_SYNC_SHORT, 8'h0a, 1'b1, 12'h0bc, 1'b0},
      '{MODE_SYNC_SHORT, 8'h0a, 1'b1, 12'h108, 1'b1},
      '{MODE_SYNC_SHORT, 8'h0a, 1'b1, 12'h158, 1'b0},
      '{MODE_SYNC_LONG, 8'h0a, 1'b1, 12'h3d8, 1'b1}, '{MODE_SYNC_LONG, 8'h0a, 1'b1, 12'h304, 1'b0},
      '{MODE_ID_POLLED, 8'h0a, 1'b1, 12'h108, 1'b1}, '{MODE_ID_POLLED, 8'h0a, 1'b1, 12'h14c, 1'b0}};
   out_mode_type to_modes [3] = '{MODE_PWM, MODE_SENT, MODE_SYNC_SHORT};
   int           to_hold [3] = '{23, 132, 264};

   aux_entry #(.FIRST_EDGE_CYC(FE), .WRITE_CYC(WR)) dut_u (
      .clk_in(clk_in), .rst_in(rst_in), .sensor_output_line_in(line_w),
      .sensor_output_line_out(dout), .sensor_output_line_oe_out(oe),
      .normal_drive_low_in(normal_drive_low_in), .mode_in(mode_in), .tick_in(tick_in),
      .sent_frame_window_in(sent_frame_window_in), .pwm_period_cyc_in(pwm_period_cyc_in),
      .eeprom_write_in(eeprom_write_in), .comm_exit_in(comm_exit_in),
      .comm_active_out(comm_active_out), .entry_abort_out(entry_abort_out));
   aux_host_model host_u (.clk_in(clk_in), .drive_low_out(host_low));

   // The clock runs at 100 MHz.
   initial
   begin
      clk_in = 1'b0;
      forever #5 clk_in = ~clk_in;
   end

   // One tick pulse every four cycles.
   always @(negedge clk_in)
   begin
      tick_div <= tick_div + 2'h1;
      tick_in  <= (tick_div == 2'h3);
   end

   // Counts and reports one comparison.
   task automatic check_bit(input string name, input logic exp, input logic got);
      n_tests++;
      if (got !== exp)
      begin
         mismatches++;
         $display("[FAIL] %s expected %b seen %b", name, exp, got);
      end
   endtask

   // Prints the verdict and stops.
   task automatic complete_run();
      if (mismatches == 0 && n_tests > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   // Waits a bounded time for the abort pulse.
   task automatic wait_abort();
      n = 0;
      while (entry_abort_out !== 1'b1 && n < FE + 100)
      begin
         @(negedge clk_in);
         n++;
      end
   endtask

   // Leaves Manchester mode.
   task automatic pulse_exit();
      comm_exit_in = 1'b1;
      @(negedge clk_in);
      comm_exit_in = 1'b0;
      repeat (4) @(negedge clk_in);
   endtask

   // Main sequence: reset, table rows, timeouts, store.
   initial
   begin
      rst_in = 1'b1;
      normal_drive_low_in = 1'b0;
      sent_frame_window_in = 1'b0;
      eeprom_write_in = 1'b0;
      comm_exit_in = 1'b0;
      mode_in = MODE_PWM;
      pwm_period_cyc_in = 32'h0000000a;
      repeat (6) @(negedge clk_in);
      rst_in = 1'b0;
      check_bit("oe_reset", 1'b0, oe);
      check_bit("comm_reset", 1'b0, comm_active_out);
      foreach (rows[i])
      begin
         mode_in = rows[i].m;
         pwm_period_cyc_in = {24'h000000, rows[i].p};
         sent_frame_window_in = rows[i].w;
         repeat (4) @(negedge clk_in);
         host_u.entry(int'(rows[i].h), GP, 6, 1'b1);
         repeat (8) @(negedge clk_in);
         check_bit("comm_active", rows[i].a, comm_active_out);
         pulse_exit();
      end
      // The device's own low phase overlaps the aux pulse.
      mode_in = MODE_PWM;
      pwm_period_cyc_in = 32'h0000000a;
      fork
         host_u.entry(23, GP, 6, 1'b1);
         begin
            repeat (4) @(negedge clk_in);
            normal_drive_low_in = 1'b1;
            repeat (8) @(negedge clk_in);
            normal_drive_low_in = 1'b0;
         end
      join
      repeat (8) @(negedge clk_in);
      check_bit("comm_overlap", 1'b1, comm_active_out);
      pulse_exit();
      // A release shorter than the edge detection time is no entry.
      host_u.entry(23, 20, 6, 1'b1);
      repeat (8) @(negedge clk_in);
      check_bit("short_release", 1'b0, comm_active_out);
      sent_frame_window_in = 1'b1;
      pwm_period_cyc_in = 32'h0000000a;
      // No first edge after release, in each mode family.
      foreach (to_modes[i])
      begin
         mode_in = to_modes[i];
         host_u.entry(to_hold[i], 0, 0, 1'b1);
         wait_abort();
         check_bit("abort_time", 1'b1, n >= FE - 5 && n <= FE + 10);
         check_bit("comm_after_abort", 1'b0, comm_active_out);
         normal_drive_low_in = 1'b1;
         repeat (3) @(negedge clk_in);
         check_bit("resume_output", 1'b1, oe);
         normal_drive_low_in = 1'b0;
         repeat (4) @(negedge clk_in);
      end
      // Host drives the gate low but never rises.
      mode_in = MODE_PWM;
      host_u.entry(23, GP, 1, 1'b0);
      wait_abort();
      check_bit("abort_low", 1'b1, n >= FE - 5 && n <= FE + 10);
      // The long low ends in a mode whose width window it misses.
      mode_in = MODE_SYNC_LONG;
      sent_frame_window_in = 1'b0;
      host_u.idle();
      repeat (10) @(negedge clk_in);
      mode_in = MODE_PWM;
      // EEPROM store, then the completion fall.
      host_u.entry(23, GP, 6, 1'b1);
      repeat (8) @(negedge clk_in);
      check_bit("comm_store", 1'b1, comm_active_out);
      eeprom_write_in = 1'b1;
      @(negedge clk_in);
      eeprom_write_in = 1'b0;
      n = 0;
      while (oe !== 1'b1 && n < 100)
      begin
         @(negedge clk_in);
         n++;
      end
      check_bit("store_time", 1'b1, n >= WR - 2 && n <= WR + 4);
      check_bit("done_fall", 1'b0, line_w);
      @(negedge clk_in);
      check_bit("done_width", 1'b0, oe);
      pulse_exit();
      complete_run();
   end

   // Cuts a hang short, at about four times the length of a clean run.
   initial
   begin
      #300000;
      mismatches++;
      complete_run();
   end
endmodule
